// >>> bus_host_model.sv
// serial bus host model driving the command port
`default_nettype none
module bus_host_model (
  // clock
  input wire logic mclk,
  // requests
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata,
  output logic read_busy,
  // answers
  input wire logic [7:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cmd_valid, cmd_write, cmd_code, cmd_wdata, read_busy} = '0;
  end
  // read_busy spans the read so the sample cannot move under it
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
    output logic [7:0] r, output logic a);
    @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = w ? d : ~cmd_wdata;
    read_busy = !w;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~cmd_wdata;
    r = cmd_rdata;
    a = cmd_done ? cmd_ack : 1'bx;
    read_busy = 1'b0;
  endtask : xfer
endmodule : bus_host_model
`default_nettype wire

// >>> sample_holder.sv
// periodic sampler: latches one telemetry byte each refresh period
`default_nettype none
module sample_holder #(
  parameter int PERIOD = 1000
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] raw,
  input wire logic hold,
  output logic [7:0] value_r
);
  localparam int CW = $clog2(PERIOD + 1);
  logic [CW-1:0] count_r;
  logic pending_r;
  logic [7:0] fresh_r;

  // --------------------------------------------------------------
  // period counter and capture
  // --------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count_r <= '0;
    end else if (count_r == CW'(PERIOD - 1)) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + 1'b1;
    end
  end

  // a sample due during a read waits until the read ends, so the byte stays whole
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pending_r <= 1'b0;
      fresh_r <= 8'h00;
      value_r <= 8'h00;
    end else begin
      if (count_r == CW'(PERIOD - 1)) begin
        fresh_r <= raw;
        pending_r <= 1'b1;
      end
      if (pending_r && !hold) begin
        value_r <= fresh_r;
        if (count_r != CW'(PERIOD - 1)) begin
          pending_r <= 1'b0;
        end
      end
    end
  end
endmodule : sample_holder
`default_nettype wire

// >>> telemetry_cfg_params.svh
// offsets, field positions, the ack value and timing counts for the telemetry and config bank
`ifndef TELEMETRY_CFG_PARAMS_SVH
`define TELEMETRY_CFG_PARAMS_SVH
`define CMD_INPUT_VOLTAGE 8'h88
`define CMD_INPUT_CURRENT 8'h89
`define CMD_OUTPUT_VOLTAGE 8'h8B
`define CMD_OUTPUT_CURRENT 8'h8C
`define CMD_DIE_TEMPERATURE 8'h8D
`define CMD_INPUT_POWER 8'h97
`define CMD_SYSTEM_CONFIG 8'hA0
`define CMD_STORE_ALL 8'h15
`define CFG_FORCED_CONT_BIT 7
`define CFG_CTRL_SRC_HI 6
`define CFG_CTRL_SRC_LO 5
`define CFG_SOFT_STOP_BIT 4
`define CFG_PG_DELAY_HI 3
`define CFG_PG_DELAY_LO 2
`define CFG_VID_ADDR_OVR_BIT 1
`define CFG_BUS_ADDR_OVR_BIT 0
`define CLK_MHZ 250
`define SLOW_PERIOD_US 190
`define FAST_PERIOD_US 95
`define SLOW_PERIOD_CYC (`SLOW_PERIOD_US * `CLK_MHZ)
`define FAST_PERIOD_CYC (`FAST_PERIOD_US * `CLK_MHZ)
`define PG_DELAY_0P5_US 500
`define PG_DELAY_1P0_US 1000
`define PG_DELAY_2P0_US 2000
`define PG_DELAY_0P5_CYC (`PG_DELAY_0P5_US * `CLK_MHZ)
`define PG_DELAY_1P0_CYC (`PG_DELAY_1P0_US * `CLK_MHZ)
`define PG_DELAY_2P0_CYC (`PG_DELAY_2P0_US * `CLK_MHZ)
`define RESP_ACK 1'b1
`endif

// >>> telemetry_cfg_pkg.sv
// types shared by the telemetry and config bank
`default_nettype none
package telemetry_cfg_pkg;
  typedef enum logic [1:0] {
    src_vid_both = 2'b00,
    src_vid_volt_bus_ofs = 2'b01,
    src_bus_both = 2'b10,
    src_bus_both_alt = 2'b11
  } ctrl_source_t;
  typedef enum logic [1:0] {
    pg_delay_0 = 2'b00,
    pg_delay_0p5 = 2'b01,
    pg_delay_1p0 = 2'b10,
    pg_delay_2p0 = 2'b11
  } pg_delay_t;
endpackage : telemetry_cfg_pkg
`default_nettype wire

// >>> telemetry_cfg_regs.sv
// telemetry readings and system configuration command registers
//
// Behaviour
// - input voltage byte, read only, refreshed every 190 us
// - input current byte, read only, refreshed every 95 us
// - output voltage byte, read only, refreshed every 190 us
// - output voltage range follows resolution; byte passed through unscaled
// - output current byte, read only, refreshed every 95 us
// - die temperature byte, read only, refreshed every 190 us
// - input power byte, read only, refreshed every 95 us
// - input current span set by sense resistor setting; byte passed unscaled
// - input power span set by full-scale setting; byte passed unscaled
// - config byte is read/write and loads its reset value from nvm
// - bit 7 picks forced continuous or discontinuous light-load mode
// - source 00: vid link drives both; voltage writes ignored, offset nacked
// - source 01: vid voltage, bus offset; vid offset writes ignored
// - source 1x: bus drives both; vid offset and set-voltage ignored
// - bit 4 low stops at once, zero turn-off delay; high uses ramp
// - bits 3:2 choose power-good delay 0, 0.5, 1.0, 2.0 ms
// - bit 1 drives the vid link address override
// - bit 0 picks strap or nvm address source
// - mode, source, soft-stop, delay fields apply only while switching off
// - address override bits apply after store-all then power cycle
`default_nettype none
`include "telemetry_cfg_params.svh"
module telemetry_cfg_regs
  import telemetry_cfg_pkg::*;
#(
  parameter int SLOW_PERIOD = `SLOW_PERIOD_CYC,
  parameter int FAST_PERIOD = `FAST_PERIOD_CYC,
  parameter int PG_0P5 = `PG_DELAY_0P5_CYC,
  parameter int PG_1P0 = `PG_DELAY_1P0_CYC,
  parameter int PG_2P0 = `PG_DELAY_2P0_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // command port from the bus interface
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire logic read_busy,
  output logic [7:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_done,
  // nvm power-on image and store
  input wire logic [7:0] nvm_config,
  output logic [7:0] nvm_store_data,
  output logic nvm_store,
  // raw measurements from the analog chain
  input wire logic [7:0] raw_input_voltage,
  input wire logic [7:0] raw_input_current,
  input wire logic [7:0] raw_output_voltage,
  input wire logic [7:0] raw_output_current,
  input wire logic [7:0] raw_die_temperature,
  input wire logic [7:0] raw_input_power,
  // power stage status and requests
  input wire logic switching_on,
  input wire logic soft_start_done,
  input wire logic vid_voltage_valid,
  input wire logic vid_offset_valid,
  input wire logic bus_voltage_valid,
  input wire logic bus_offset_valid,
  // applied configuration
  output logic forced_continuous_select,
  output logic [1:0] control_source_select,
  output logic soft_stop_enable,
  output logic power_good_output,
  output logic bus_address_override,
  output logic vid_link_address_override,
  output logic voltage_from_bus,
  output logic offset_from_bus,
  output logic voltage_update,
  output logic offset_update
);
  // ------------------------------------------------------------
  // telemetry samplers
  // ------------------------------------------------------------
  localparam int NCH = 6;
  logic [7:0] raw_sync1_r [NCH];
  logic [7:0] raw_sync2_r [NCH];
  logic [7:0] sample [NCH];
  logic [7:0] raw_in [NCH];
  assign raw_in[0] = raw_input_voltage;
  assign raw_in[1] = raw_input_current;
  assign raw_in[2] = raw_output_voltage;
  assign raw_in[3] = raw_output_current;
  assign raw_in[4] = raw_die_temperature;
  assign raw_in[5] = raw_input_power;

  // analog side is asynchronous: two flops per byte before sampling
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NCH; i++) begin
      raw_sync1_r[i] <= raw_in[i];
      raw_sync2_r[i] <= raw_sync1_r[i];
    end
  end

  // channels 0,2,4 slow, 1,3,5 fast
  sample_holder #(.PERIOD(SLOW_PERIOD)) u_vin (
    .mclk(mclk), .resetn(resetn), .raw(raw_sync2_r[0]), .hold(read_busy),
    .value_r(sample[0]));
  sample_holder #(.PERIOD(FAST_PERIOD)) u_iin (
    .mclk(mclk), .resetn(resetn), .raw(raw_sync2_r[1]), .hold(read_busy),
    .value_r(sample[1]));
  sample_holder #(.PERIOD(SLOW_PERIOD)) u_vout (
    .mclk(mclk), .resetn(resetn), .raw(raw_sync2_r[2]), .hold(read_busy),
    .value_r(sample[2]));
  sample_holder #(.PERIOD(FAST_PERIOD)) u_iout (
    .mclk(mclk), .resetn(resetn), .raw(raw_sync2_r[3]), .hold(read_busy),
    .value_r(sample[3]));
  sample_holder #(.PERIOD(SLOW_PERIOD)) u_temp (
    .mclk(mclk), .resetn(resetn), .raw(raw_sync2_r[4]), .hold(read_busy),
    .value_r(sample[4]));
  sample_holder #(.PERIOD(FAST_PERIOD)) u_pin (
    .mclk(mclk), .resetn(resetn), .raw(raw_sync2_r[5]), .hold(read_busy),
    .value_r(sample[5]));

  // ------------------------------------------------------------
  // input synchronisers for power stage status
  // ------------------------------------------------------------
  logic [5:0] st_sync1_r;
  logic [5:0] st_sync2_r;
  always_ff @(posedge mclk) begin
    st_sync1_r <= {switching_on, soft_start_done, vid_voltage_valid,
                   vid_offset_valid, bus_voltage_valid, bus_offset_valid};
    st_sync2_r <= st_sync1_r;
  end
  logic sw_on;
  logic ss_done;
  assign sw_on = st_sync2_r[5];
  assign ss_done = st_sync2_r[4];

  // ------------------------------------------------------------
  // config register: stored image
  // ------------------------------------------------------------
  logic load_done_r;
  logic [7:0] cfg_r;
  logic cfg_wr;
  assign cfg_wr = cmd_valid && cmd_write && cmd_code == `CMD_SYSTEM_CONFIG;

  // nvm image caught by a clocked load after release, not by the reset itself
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      load_done_r <= 1'b0;
      cfg_r <= 8'h00;
    end else if (!load_done_r) begin
      load_done_r <= 1'b1;
      cfg_r <= nvm_config;
    end else if (cfg_wr) begin
      cfg_r <= cmd_wdata;
    end
  end

  // ------------------------------------------------------------
  // applied fields: live copy follows storage only while idle
  // ------------------------------------------------------------
  logic [5:0] live_r;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      live_r <= 6'h00;
    end else if (load_done_r && !sw_on) begin
      live_r <= cfg_r[`CFG_FORCED_CONT_BIT:`CFG_PG_DELAY_LO];
    end
  end

  // address override bits latched once at power-on only
  logic [1:0] addr_ovr_r;
  logic addr_taken_r;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      addr_ovr_r <= 2'b00;
      addr_taken_r <= 1'b0;
    end else if (!addr_taken_r && load_done_r) begin
      addr_ovr_r <= cfg_r[`CFG_VID_ADDR_OVR_BIT:`CFG_BUS_ADDR_OVR_BIT];
      addr_taken_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      forced_continuous_select <= 1'b0;
      control_source_select <= 2'b00;
      soft_stop_enable <= 1'b0;
      bus_address_override <= 1'b0;
      vid_link_address_override <= 1'b0;
    end else begin
      forced_continuous_select <= live_r[5];
      control_source_select <= live_r[4:3];
      soft_stop_enable <= live_r[2];
      bus_address_override <= addr_ovr_r[0];
      vid_link_address_override <= addr_ovr_r[1];
    end
  end

  // ------------------------------------------------------------
  // control source steering
  // ------------------------------------------------------------
  ctrl_source_t src;
  assign src = ctrl_source_t'(live_r[4:3]);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      voltage_from_bus <= 1'b0;
      offset_from_bus <= 1'b0;
      voltage_update <= 1'b0;
      offset_update <= 1'b0;
    end else begin
      case (src)
        src_vid_both: begin
          voltage_from_bus <= 1'b0;
          offset_from_bus <= 1'b0;
          voltage_update <= st_sync2_r[3];
          offset_update <= st_sync2_r[2];
        end
        src_vid_volt_bus_ofs: begin
          voltage_from_bus <= 1'b0;
          offset_from_bus <= 1'b1;
          voltage_update <= st_sync2_r[3];
          offset_update <= st_sync2_r[0];
        end
        src_bus_both, src_bus_both_alt: begin
          voltage_from_bus <= 1'b1;
          offset_from_bus <= 1'b1;
          voltage_update <= st_sync2_r[1];
          offset_update <= st_sync2_r[0];
        end
        default: begin
          voltage_from_bus <= 1'b0;
          offset_from_bus <= 1'b0;
          voltage_update <= 1'b0;
          offset_update <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // power-good delay after soft start
  // ------------------------------------------------------------
  localparam int PGW = $clog2(PG_2P0 + 1);
  logic [PGW-1:0] pg_count_r;
  logic [PGW-1:0] pg_target;
  always_comb begin
    case (pg_delay_t'(live_r[1:0]))
      pg_delay_0: pg_target = '0;
      pg_delay_0p5: pg_target = PGW'(PG_0P5);
      pg_delay_1p0: pg_target = PGW'(PG_1P0);
      pg_delay_2p0: pg_target = PGW'(PG_2P0);
      default: pg_target = '0;
    endcase
  end

  // count parks at the target, so power good stays up until either status drops
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pg_count_r <= '0;
      power_good_output <= 1'b0;
    end else if (!ss_done || !sw_on) begin
      pg_count_r <= '0;
      power_good_output <= 1'b0;
    end else if (pg_count_r >= pg_target) begin
      power_good_output <= 1'b1;
    end else begin
      pg_count_r <= pg_count_r + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // command port: reads, acks, store-all
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cmd_rdata <= 8'h00;
      cmd_ack <= 1'b0;
      cmd_done <= 1'b0;
      nvm_store <= 1'b0;
      nvm_store_data <= 8'h00;
    end else begin
      cmd_done <= cmd_valid;
      cmd_ack <= 1'b0;
      nvm_store <= 1'b0;
      if (cmd_valid && !cmd_write) begin
        cmd_ack <= `RESP_ACK;
        case (cmd_code)
          `CMD_INPUT_VOLTAGE: cmd_rdata <= sample[0];
          `CMD_INPUT_CURRENT: cmd_rdata <= sample[1];
          `CMD_OUTPUT_VOLTAGE: cmd_rdata <= sample[2];
          `CMD_OUTPUT_CURRENT: cmd_rdata <= sample[3];
          `CMD_DIE_TEMPERATURE: cmd_rdata <= sample[4];
          `CMD_INPUT_POWER: cmd_rdata <= sample[5];
          `CMD_SYSTEM_CONFIG: cmd_rdata <= cfg_r;
          default: begin
            cmd_rdata <= 8'h00;
            cmd_ack <= 1'b0;
          end
        endcase
      end else if (cmd_valid && cmd_write) begin
        // telemetry codes have no write; they are nacked
        if (cmd_code == `CMD_SYSTEM_CONFIG) begin
          cmd_ack <= `RESP_ACK;
        end else if (cmd_code == `CMD_STORE_ALL) begin
          cmd_ack <= `RESP_ACK;
          nvm_store <= 1'b1;
          nvm_store_data <= cfg_r;
        end
      end
    end
  end
endmodule : telemetry_cfg_regs
`default_nettype wire

// >>> telemetry_cfg_regs_properties.sv
// port assertions for the telemetry and config bank
`default_nettype none
module telemetry_cfg_regs_properties (
  // clock
  input wire logic mclk,
  input wire logic resetn,
  // commands
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_done,
  input wire logic nvm_store,
  // config
  input wire logic switching_on,
  input wire logic forced_continuous_select,
  input wire logic [1:0] control_source_select,
  input wire logic soft_stop_enable,
  input wire logic bus_address_override,
  input wire logic vid_link_address_override
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // --
  // helpers
  // --
  logic [2:0] up_r;
  wire logic rd = cmd_valid && !cmd_write;
  wire logic wr = cmd_valid && cmd_write;
  wire logic telem = cmd_code inside {8'h88, 8'h89, 8'h8B, 8'h8C, 8'h8D, 8'h97};
  // startup loads would look like late changes without this
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h7) begin
      up_r <= up_r + 3'h1;
    end
  end
  // --
  // properties
  // --
  answer_timing_a: assert property (1'b1 |=> cmd_done == $past(cmd_valid))
    else $error("answer not one cycle after command");
  telem_read_ack_a: assert property (rd && telem |=> cmd_ack)
    else $error("telemetry read refused");
  telem_write_nack_a: assert property (wr && telem |=> !cmd_ack)
    else $error("telemetry write accepted");
  cfg_write_ack_a: assert property (wr && cmd_code == 8'hA0 |=> cmd_ack)
    else $error("config write refused");
  cfg_readback_a: assert property (wr && cmd_code == 8'hA0 ##1 !cmd_valid
    ##1 rd && cmd_code == 8'hA0 |=> cmd_rdata == $past(cmd_wdata, 3))
    else $error("config readback differs");
  store_pulse_a: assert property (wr && cmd_code == 8'h15 |=> nvm_store)
    else $error("store-all gave no store pulse");
  store_cause_a: assert property (nvm_store |-> $past(wr && cmd_code == 8'h15))
    else $error("store pulse without store-all");
  applied_frozen_a: assert property (up_r == 3'h7 && switching_on [*6] |->
    $stable(forced_continuous_select) && $stable(control_source_select)
    && $stable(soft_stop_enable)) else $error("applied config moved while switching");
  override_hold_a: assert property (up_r == 3'h7 |-> $stable(bus_address_override)
    && $stable(vid_link_address_override)) else $error("address override moved after startup");
endmodule : telemetry_cfg_regs_properties
bind telemetry_cfg_regs telemetry_cfg_regs_properties i_props (.mclk, .resetn, .cmd_valid,
  .cmd_write, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_ack, .cmd_done, .nvm_store, .switching_on,
  .forced_continuous_select, .control_source_select, .soft_stop_enable, .bus_address_override,
  .vid_link_address_override);
`default_nettype wire

// >>> telemetry_cfg_regs_tb_top.sv
// self-checking bench for the telemetry and config bank
`default_nettype none
module telemetry_cfg_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] cfg; logic vb; logic ob;} row_t;
  row_t rows [4] = '{'{8'h12, 1'b0, 1'b0}, '{8'hA8, 1'b0, 1'b1}, '{8'h54, 1'b1, 1'b1},
    '{8'hF6, 1'b1, 1'b1}};
  logic [7:0] tcode [6] = '{8'h88, 8'h89, 8'h8B, 8'h8C, 8'h8D, 8'h97};
  int pgd [4] = '{0, 4, 8, 16};
  logic mclk, resetn, switching_on, soft_start_done, cmd_valid, cmd_write, read_busy;
  logic cmd_ack, cmd_done, nvm_store, fcs, sse, pgo, bao, vao, vfb, ofb, ak;
  logic vu, ou, vid_v, vid_o, bus_v, bus_o;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, nvm_config, nvm_store_data, rd;
  logic [7:0] raw [6];
  logic [1:0] css;
  int error_cnt = 0, num_checks = 0, cyc = 0, n;
  telemetry_cfg_regs #(.SLOW_PERIOD(20), .FAST_PERIOD(10), .PG_0P5(4), .PG_1P0(8), .PG_2P0(16))
    i_telemetry_cfg_regs (.mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .read_busy(read_busy),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_done(cmd_done), .nvm_config(nvm_config),
    .nvm_store_data(nvm_store_data), .nvm_store(nvm_store), .raw_input_voltage(raw[0]),
    .raw_input_current(raw[1]), .raw_output_voltage(raw[2]), .raw_output_current(raw[3]),
    .raw_die_temperature(raw[4]), .raw_input_power(raw[5]), .switching_on(switching_on),
    .soft_start_done(soft_start_done), .vid_voltage_valid(vid_v), .vid_offset_valid(vid_o),
    .bus_voltage_valid(bus_v), .bus_offset_valid(bus_o), .forced_continuous_select(fcs),
    .control_source_select(css), .soft_stop_enable(sse), .power_good_output(pgo),
    .bus_address_override(bao), .vid_link_address_override(vao), .voltage_from_bus(vfb),
    .offset_from_bus(ofb), .voltage_update(vu), .offset_update(ou));
  bus_host_model i_bus_host_model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .read_busy(read_busy), .cmd_rdata(cmd_rdata),
    .cmd_ack(cmd_ack), .cmd_done(cmd_done));
  // --
  // tasks
  // --
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] d);
    i_bus_host_model.xfer(w, c, d, rd, ak);
  endtask : cmd
  task automatic do_reset;
    resetn = 1'b0;
    repeat (5) @(posedge mclk);
    check(cmd_done === 1'b0 && pgo === 1'b0, "outputs during reset");
    #1 resetn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
  endtask : do_reset
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // run is a few hundred cycles; this only cuts a hang
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      check(1'b0, "timeout");
      summarize();
    end
  end
  // --
  // sequence
  // --
  initial begin
    resetn = 1'b0;
    switching_on = 1'b0;
    soft_start_done = 1'b0;
    {vid_v, vid_o, bus_v, bus_o} = 4'h0;
    nvm_config = 8'h01;
    foreach (raw[k]) raw[k] = 8'h31 + 8'(k * 37);
    do_reset();
    cmd(1'b0, 8'hA0, 8'h00);
    check(rd === 8'h01 && bao === 1'b1 && vao === 1'b0, "power-on config");
    foreach (rows[i]) begin
      cmd(1'b1, 8'hA0, rows[i].cfg);
      cmd(1'b0, 8'hA0, 8'h00);
      check(rd === rows[i].cfg, "config readback");
      repeat (6) @(posedge mclk);
      #1;
      check(fcs === rows[i].cfg[7] && css === rows[i].cfg[6:5], "mode or source");
      check(sse === rows[i].cfg[4], "soft stop");
      check(vfb === rows[i].vb && ofb === rows[i].ob, "source steering");
      // two opposite request patterns, so each source pick is told apart
      {vid_v, vid_o, bus_v, bus_o} = 4'h9;
      repeat (4) @(posedge mclk);
      #1;
      check(vu === !rows[i].vb && ou === rows[i].ob, "update steering");
      {vid_v, vid_o, bus_v, bus_o} = 4'h6;
      repeat (4) @(posedge mclk);
      #1;
      check(vu === rows[i].vb && ou === !rows[i].ob, "update steering");
    end
    foreach (raw[k]) raw[k] = 8'hFF - 8'(k * 29);
    repeat (30) @(posedge mclk);
    foreach (tcode[k]) begin
      cmd(1'b0, tcode[k], 8'h00);
      check(ak === 1'b1 && rd === raw[k], "telemetry read");
      cmd(1'b1, tcode[k], 8'h5A);
      check(ak === 1'b0, "telemetry write taken");
    end
    cmd(1'b0, 8'h90, 8'h00);
    check(ak === 1'b0 && rd === 8'h00, "unknown read");
    for (int d = 0; d < 4; d++) begin
      switching_on = 1'b0;
      soft_start_done = 1'b0;
      cmd(1'b1, 8'hA0, {4'h1, 2'(d), 2'b00});
      repeat (8) @(posedge mclk);
      #1 switching_on = 1'b1;
      soft_start_done = 1'b1;
      n = 0;
      while (pgo !== 1'b1 && n < 40) begin
        @(posedge mclk);
        #1 n++;
      end
      check(n >= pgd[d] && n <= pgd[d] + 5, "power good delay");
    end
    cmd(1'b1, 8'hA0, 8'hFC);
    repeat (6) @(posedge mclk);
    #1;
    check(fcs === 1'b0 && css === 2'b00, "applied while switching");
    cmd(1'b0, 8'hA0, 8'h00);
    check(rd === 8'hFC, "stored while switching");
    switching_on = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    check(fcs === 1'b1 && css === 2'b11, "not applied when idle");
    cmd(1'b1, 8'hA0, 8'h02);
    check(bao === 1'b1, "override applied early");
    cmd(1'b1, 8'h15, 8'h00);
    check(nvm_store === 1'b1 && nvm_store_data === 8'h02, "store-all");
    nvm_config = 8'h02;
    do_reset();
    cmd(1'b0, 8'hA0, 8'h00);
    check(rd === 8'h02 && bao === 1'b0 && vao === 1'b1, "override after cycle");
    summarize();
  end
endmodule : telemetry_cfg_regs_tb_top
`default_nettype wire
